//--- hw/bbr_status_regs.sv
/*
 * Status and measurement read-back bank of the direct-sequence
 * baseband, with seed and view configuration, as a classic Wishbone
 * slave.
 * Assumes all datapath inputs run on CLK_I and the bus master holds a
 * request until it sees ACK_O or ERR_O.
 */
// The Wishbone register port was decided locally.
`timescale 1ns/1ps

// Contract
// - Test bus register returns the live 8-bit test bus in both views.
// - Config bit picks long or short 7-bit scrambler seed to apply.
// - View a at 66h: antenna one noise floor, unsigned 0 to 255.
// - View a at 68h: antenna two noise floor, unsigned 0 to 255.
// - View b at 66h: carrier loop signal quality figure.
// - View b at 68h: signal field of last received header.
// - View a at 6Ah: in-phase DC offset, signed sxxxx.xx.
// - View b at 6Ah: service field of last received header.
// - View a at 6Ch: quadrature DC offset, signed sxxxx.xx.
// - View b at 6Ch: received length field, low byte.
// - View a at 6Eh: multipath metric of last packet.
// - View b at 6Eh: received length field, high byte.
// - View a at 70h: count of last 15 packets above threshold.
// - View b at 70h: computed header CRC, low byte.
// - View a at 72h: packet quality, read after processing enable drops.
// - View b at 72h: computed header CRC, high byte.
// - 74h: signed transmit power, 64-sample average, both views.
// - View a at 78h: header quality, valid after processing enable drops.
// - View b at 78h: mean received power in dB, -33 to 0.
// - 7Ah: IF gain in bits 6:0, bit 7 reads zero.
// - Seed register bit 7 at zero shows b content.
module bbr_status_regs (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic [9:0] ADR_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic ERR_O,
    input wire bbr_pkg::bbr_meas_t MEAS_I,
    output logic [bbr_pkg::SEED_W-1:0] SEED_O,
    output logic [bbr_pkg::MP_THR_W-1:0] MP_THR_O
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
        logic [7:0] seed_select_config_reg;
        logic [7:0] multipath_threshold_reg;
        logic [7:0] long_preamble_seed_reg;
        logic [7:0] short_seed_and_view_reg;
        logic [bbr_pkg::SEED_W-1:0] seed;
        logic [7:0] signal_field;
        logic [7:0] service_field;
        logic [15:0] length_field;
        logic [15:0] header_crc;
        logic [7:0] multipath;
        logic [7:0] packet_quality;
        logic [7:0] header_quality;
        logic receive_processing_enable_d;
    } bbr_regs_state_t;

    bbr_regs_state_t st_r;
    bbr_regs_state_t st_nxt;

    bbr_pkg::bbr_wb_req_t req;
    logic [7:0] idx;
    logic view_a;
    logic mapped;
    logic [7:0] rd_mux;
    logic [7:0] mp_count;
    logic [7:0] tx_power;
    logic receive_processing_enable_fall;

    assign req = '{cyc: CYC_I, stb: STB_I, we: WE_I, sel: SEL_I, adr: ADR_I, dat: DAT_I};
    assign idx = req.adr[9:2];
    assign view_a = st_r.short_seed_and_view_reg[bbr_pkg::VIEW_SEL_BIT];
    assign receive_processing_enable_fall = st_r.receive_processing_enable_d & ~MEAS_I.receive_processing_enable;

    // ----------------------------------------------------------------
    // Measurement helpers
    // ----------------------------------------------------------------
    bbr_mp_count #(
        .DEPTH(bbr_pkg::MP_HISTORY)
    ) u_mp_count (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .packet_i(MEAS_I.packet_done),
        .metric_i(MEAS_I.multipath_metric),
        .thr_i(st_r.multipath_threshold_reg[bbr_pkg::MP_THR_LSB +: bbr_pkg::MP_THR_W]),
        .count_o(mp_count)
    );

    bbr_tx_avg #(
        .LOG2_N(bbr_pkg::TX_AVG_LOG2)
    ) u_tx_avg (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .sample_valid_i(MEAS_I.tx_sample_valid),
        .sample_i(MEAS_I.tx_sample),
        .avg_o(tx_power)
    );

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    // Dual-view entries pick a when the view bit is one, else b
    always_comb begin
        rd_mux = 8'h00;
        mapped = 1'b1;
        unique case (idx)
            bbr_pkg::IDX_SEED_CFG: begin
                rd_mux = st_r.seed_select_config_reg;
            end
            bbr_pkg::IDX_MP_THR: begin
                rd_mux = st_r.multipath_threshold_reg;
            end
            bbr_pkg::IDX_LONG_SEED: begin
                rd_mux = st_r.long_preamble_seed_reg;
            end
            bbr_pkg::IDX_SHORT_SEED: begin
                rd_mux = st_r.short_seed_and_view_reg;
            end
            bbr_pkg::IDX_TEST_BUS: begin
                rd_mux = MEAS_I.test_bus;
            end
            bbr_pkg::IDX_NOISE_A_SNR: begin
                rd_mux = view_a ? MEAS_I.antenna_one_noise_level : MEAS_I.snr_quality;
            end
            bbr_pkg::IDX_NOISE_B_SIG: begin
                rd_mux = view_a ? MEAS_I.antenna_two_noise_level : st_r.signal_field;
            end
            bbr_pkg::IDX_I_OFS_SERVICE: begin
                rd_mux = view_a ? MEAS_I.i_offset : st_r.service_field;
            end
            bbr_pkg::IDX_Q_OFS_LEN_LO: begin
                rd_mux = view_a ? MEAS_I.q_offset : st_r.length_field[7:0];
            end
            bbr_pkg::IDX_MP_LEN_HI: begin
                rd_mux = view_a ? st_r.multipath : st_r.length_field[15:8];
            end
            bbr_pkg::IDX_MP_CNT_CRC_LO: begin
                rd_mux = view_a ? mp_count : st_r.header_crc[7:0];
            end
            bbr_pkg::IDX_PKT_Q_CRC_HI: begin
                rd_mux = view_a ? st_r.packet_quality : st_r.header_crc[15:8];
            end
            bbr_pkg::IDX_TX_POWER: begin
                rd_mux = tx_power;
            end
            bbr_pkg::IDX_HDR_Q_MEAN_PWR: begin
                rd_mux = view_a ? st_r.header_quality : MEAS_I.mean_power;
            end
            bbr_pkg::IDX_IF_GAIN: begin
                rd_mux = {1'b0, MEAS_I.intermediate_gain_output};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.receive_processing_enable_d = MEAS_I.receive_processing_enable;

        // Answer one cycle after the request, then drop for a cycle
        if (req.cyc && req.stb && !st_r.ack && !st_r.err) begin
            st_nxt.ack = mapped;
            st_nxt.err = ~mapped;
            st_nxt.rdata = mapped ? rd_mux : 8'h00;
            // Read-only entries take writes silently
            if (req.we && req.sel[0]) begin
                unique case (idx)
                    bbr_pkg::IDX_SEED_CFG: begin
                        st_nxt.seed_select_config_reg = req.dat[7:0];
                    end
                    bbr_pkg::IDX_MP_THR: begin
                        st_nxt.multipath_threshold_reg = req.dat[7:0];
                    end
                    bbr_pkg::IDX_LONG_SEED: begin
                        st_nxt.long_preamble_seed_reg = req.dat[7:0];
                    end
                    bbr_pkg::IDX_SHORT_SEED: begin
                        st_nxt.short_seed_and_view_reg = req.dat[7:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Applied seed follows the select bit; one is the short seed
        if (st_r.seed_select_config_reg[bbr_pkg::SEED_SEL_BIT]) begin
            st_nxt.seed = st_r.short_seed_and_view_reg[bbr_pkg::SEED_W-1:0];
        end else begin
            st_nxt.seed = st_r.long_preamble_seed_reg[bbr_pkg::SEED_W-1:0];
        end

        // Header fields stand until the next valid header
        if (MEAS_I.header_valid) begin
            st_nxt.signal_field = MEAS_I.signal_field;
            st_nxt.service_field = MEAS_I.service_field;
            st_nxt.length_field = MEAS_I.length_field;
            st_nxt.header_crc = MEAS_I.header_crc;
        end

        if (MEAS_I.packet_done) begin
            st_nxt.multipath = MEAS_I.multipath_metric;
        end

        // Quality figures are final only once processing stops
        if (receive_processing_enable_fall) begin
            st_nxt.packet_quality = MEAS_I.packet_quality;
            st_nxt.header_quality = MEAS_I.header_quality;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_r <= '0;
            st_r.seed_select_config_reg <= bbr_pkg::RST_SEED_CFG;
            st_r.multipath_threshold_reg <= bbr_pkg::RST_MP_THR;
            st_r.long_preamble_seed_reg <= bbr_pkg::RST_LONG_SEED;
            st_r.short_seed_and_view_reg <= bbr_pkg::RST_SHORT_SEED;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign DAT_O = {24'h000000, st_r.rdata};
    assign ACK_O = st_r.ack;
    assign ERR_O = st_r.err;
    assign SEED_O = st_r.seed;
    assign MP_THR_O = st_r.multipath_threshold_reg[bbr_pkg::MP_THR_LSB +: bbr_pkg::MP_THR_W];

endmodule // bbr_status_regs

//--- hw/bbr_pkg.sv
/*
 * Package of the baseband status read-back block: register indexes,
 * field positions, reset values and the carrier structs.
 * Assumes a 32-bit classic Wishbone bus whose byte address is four
 * times the register index.
 */
package bbr_pkg;

    // ----------------------------------------------------------------
    // Register indexes
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_SEED_CFG = 8'h0a;
    localparam logic [7:0] IDX_MP_THR = 8'h48;
    localparam logic [7:0] IDX_LONG_SEED = 8'h60;
    localparam logic [7:0] IDX_SHORT_SEED = 8'h62;
    localparam logic [7:0] IDX_TEST_BUS = 8'h64;
    localparam logic [7:0] IDX_NOISE_A_SNR = 8'h66;
    localparam logic [7:0] IDX_NOISE_B_SIG = 8'h68;
    localparam logic [7:0] IDX_I_OFS_SERVICE = 8'h6a;
    localparam logic [7:0] IDX_Q_OFS_LEN_LO = 8'h6c;
    localparam logic [7:0] IDX_MP_LEN_HI = 8'h6e;
    localparam logic [7:0] IDX_MP_CNT_CRC_LO = 8'h70;
    localparam logic [7:0] IDX_PKT_Q_CRC_HI = 8'h72;
    localparam logic [7:0] IDX_TX_POWER = 8'h74;
    localparam logic [7:0] IDX_HDR_Q_MEAN_PWR = 8'h78;
    localparam logic [7:0] IDX_IF_GAIN = 8'h7a;

    // ----------------------------------------------------------------
    // Field positions and widths
    // ----------------------------------------------------------------
    localparam int SEED_SEL_BIT = 3;
    localparam int VIEW_SEL_BIT = 7;
    localparam int MP_THR_LSB = 5;
    localparam int MP_THR_W = 3;
    localparam int SEED_W = 7;
    localparam int IF_GAIN_W = 7;
    localparam int MP_HISTORY = 15;
    localparam int TX_AVG_LOG2 = 6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_SEED_CFG = 8'h00;
    localparam logic [7:0] RST_MP_THR = 8'h00;
    localparam logic [7:0] RST_LONG_SEED = 8'h00;
    localparam logic [7:0] RST_SHORT_SEED = 8'h00;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // Live and per-packet values from the receive and transmit datapath
    typedef struct packed {
        logic [7:0] test_bus;
        logic [7:0] antenna_one_noise_level;
        logic [7:0] antenna_two_noise_level;
        logic [7:0] snr_quality;
        logic [7:0] i_offset;
        logic [7:0] q_offset;
        logic header_valid;
        logic [7:0] signal_field;
        logic [7:0] service_field;
        logic [15:0] length_field;
        logic [15:0] header_crc;
        logic packet_done;
        logic [7:0] multipath_metric;
        logic receive_processing_enable;
        logic [7:0] packet_quality;
        logic [7:0] header_quality;
        logic [7:0] mean_power;
        logic tx_sample_valid;
        logic [7:0] tx_sample;
        logic [IF_GAIN_W-1:0] intermediate_gain_output;
    } bbr_meas_t;

    // Wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } bbr_wb_req_t;

endpackage

//--- hw/bbr_mp_count.sv
/*
 * Sliding count of recent packets whose multipath metric exceeded a
 * 3-bit threshold.
 * Assumes one packet_i pulse per received packet, same clock.
 */
`timescale 1ns/1ps

module bbr_mp_count #(
    parameter int DEPTH = 15
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic packet_i,
    input wire logic [7:0] metric_i,
    input wire logic [2:0] thr_i,
    output logic [7:0] count_o
);

    typedef struct packed {
        logic [DEPTH-1:0] hist;
        logic [7:0] count;
    } bbr_mpc_state_t;

    bbr_mpc_state_t st_r;
    bbr_mpc_state_t st_nxt;
    logic above;

    // Threshold weighs the top three metric bits
    assign above = (metric_i[7:5] > thr_i);

    // Running sum avoids a 15-input adder: add newest, drop oldest
    always_comb begin
        st_nxt = st_r;
        if (packet_i) begin
            st_nxt.hist = {st_r.hist[DEPTH-2:0], above};
            st_nxt.count = st_r.count + {7'h00, above} - {7'h00, st_r.hist[DEPTH-1]};
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_o = st_r.count;

endmodule // bbr_mp_count

//--- hw/bbr_tx_avg.sv
/*
 * Block average of signed transmit power samples.
 * Assumes sample_valid_i from logic on the same clock.
 */
`timescale 1ns/1ps

module bbr_tx_avg #(
    parameter int LOG2_N = 6
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sample_valid_i,
    input wire logic [7:0] sample_i,
    output logic [7:0] avg_o
);

    typedef struct packed {
        logic [LOG2_N-1:0] cnt;
        logic [LOG2_N+7:0] sum;
        logic [7:0] avg;
    } bbr_avg_state_t;

    bbr_avg_state_t st_r;
    bbr_avg_state_t st_nxt;
    logic [LOG2_N+7:0] sum_new;

    assign sum_new = st_r.sum + {{LOG2_N{sample_i[7]}}, sample_i};

    // Result holds until the next full block; partial blocks never show
    always_comb begin
        st_nxt = st_r;
        if (sample_valid_i) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (&st_r.cnt) begin
                st_nxt.avg = sum_new[LOG2_N+7:LOG2_N];
                st_nxt.sum = '0;
            end else begin
                st_nxt.sum = sum_new;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avg_o = st_r.avg;

endmodule // bbr_tx_avg

//--- sim/bbr_status_regs_monitor.sv
/*
 * Checker of the status read-back bank: bus answer timing, data hold
 * and the live single-view reads.
 * Assumes it is bound to bbr_status_regs and sees only its ports.
 */
`timescale 1ns/1ps

module bbr_status_regs_chk (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic [9:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic ERR_O,
    input wire bbr_pkg::bbr_meas_t MEAS_I,
    input wire logic [bbr_pkg::SEED_W-1:0] SEED_O,
    input wire logic [bbr_pkg::MP_THR_W-1:0] MP_THR_O
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    logic take;
    logic mapped;
    assign take = CYC_I && STB_I && !ACK_O && !ERR_O;
    always_comb begin
        mapped = ADR_I[9:2] inside {8'h0a, 8'h48, 8'h60, 8'h62, 8'h64, 8'h66, 8'h68,
            8'h6a, 8'h6c, 8'h6e, 8'h70, 8'h72, 8'h74, 8'h78, 8'h7a};
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_rd(logic [7:0] idx);
        take && !WE_I && ADR_I[9:2] == idx;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_answer_next: assert property (take |=> (ACK_O || ERR_O))
        else $error("request not answered in one cycle");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_no_both: assert property (!(ACK_O && ERR_O))
        else $error("ack and err together");
    a_mapped_ack: assert property (take && mapped |=> ACK_O && !ERR_O)
        else $error("mapped index not acked");
    a_unmapped_err: assert property (take && !mapped |=> ERR_O && !ACK_O && DAT_O == 32'h0)
        else $error("unmapped index not refused");
    a_data_hold: assert property (!take |=> $stable(DAT_O))
        else $error("read data moved without request");
    a_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_test_bus: assert property (s_rd(8'h64) |=> DAT_O[7:0] == $past(MEAS_I.test_bus))
        else $error("test bus read wrong");
    a_if_gain: assert property (s_rd(8'h7a) |=> DAT_O[7:0] == {1'b0, $past(MEAS_I.intermediate_gain_output)})
        else $error("if gain read wrong");
endmodule // bbr_status_regs_chk

bind bbr_status_regs bbr_status_regs_chk i_chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .SEL_I(SEL_I), .ADR_I(ADR_I),
    .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O), .MEAS_I(MEAS_I),
    .SEED_O(SEED_O), .MP_THR_O(MP_THR_O));

//--- sim/bbr_status_regs_test.sv
/*
 * Self-checking bench of the status read-back bank over Wishbone.
 * Assumes the bank answers one cycle after taking a request.
 */
`timescale 1ns/1ps

module bbr_status_regs_test;
    logic clk, nrst, cyc, stb, we, ack, err;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat_w, dat_o;
    logic [6:0] seed;
    logic [2:0] thr;
    bbr_pkg::bbr_meas_t m;
    int failures = 0;
    int n_checks = 0;
    logic [7:0] ix[8] = '{8'h66, 8'h68, 8'h6a, 8'h6c, 8'h6e, 8'h70, 8'h72, 8'h78};
    logic [7:0] eb[8] = '{8'h42, 8'h0a, 8'h04, 8'h34, 8'h12, 8'hef, 8'hbe, 8'hdf};
    logic [7:0] ea[8] = '{8'h9f, 8'h11, 8'hf5, 8'h0b, 8'h80, 8'h00, 8'h27, 8'h19};

    bbr_status_regs i_dut (.CLK_I(clk), .NRST_I(nrst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .SEL_I(sel), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_o),
        .ACK_O(ack), .ERR_O(err), .MEAS_I(m), .SEED_O(seed), .MP_THR_O(thr));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("Error %0t: got %h want %h", $time, g, x);
        end
    endtask

    // Samples at the ack edge, before that edge's updates land
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [3:0] s, output logic [7:0] rd, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'b00};
        dat_w <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        rd = dat_o[7:0];
        e = err;
        if (n >= 50) begin
            failures++;
            $display("Error %0t: no bus answer", $time);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] x);
        logic [7:0] d;
        logic e;
        wb(1'b0, idx, 8'h00, 4'hf, d, e);
        chk(d, x);
        chk({7'h0, e}, 8'h00);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] d;
        logic e;
        wb(1'b1, idx, v, 4'hf, d, e);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (8000) @(posedge clk);
        failures++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d, mv;
        logic e;
        int s;
        nrst = 1'b0;
        {cyc, stb, we, sel, adr, dat_w} = '0;
        m = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        chk({1'b0, seed}, 8'h00);
        chk({5'h0, thr}, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h48, 8'h00);
        rd(8'h60, 8'h00);
        rd(8'h62, 8'h00);
        $display("Test reset done");
        @(posedge clk);
        m.test_bus <= 8'h3c;
        m.antenna_one_noise_level <= 8'h9f;
        m.antenna_two_noise_level <= 8'h11;
        m.snr_quality <= 8'h42;
        m.i_offset <= 8'hf5;
        m.q_offset <= 8'h0b;
        m.mean_power <= 8'hdf;
        m.intermediate_gain_output <= 7'h7f;
        {m.signal_field, m.service_field} <= 16'h0a04;
        {m.length_field, m.header_crc} <= 32'h1234_beef;
        m.header_valid <= 1'b1;
        m.receive_processing_enable <= 1'b1;
        @(posedge clk);
        m.header_valid <= 1'b0;
        {m.signal_field, m.service_field, m.length_field, m.header_crc} <= '0;
        m.receive_processing_enable <= 1'b0;
        {m.packet_quality, m.header_quality} <= 16'h2719;
        @(posedge clk);
        {m.packet_quality, m.header_quality} <= 16'h0;
        // Threshold 3: metric top field 3 is the boundary and must not count
        wr(8'h48, 8'h60);
        chk({5'h0, thr}, 8'h03);
        for (int k = 0; k < 16; k++) begin
            mv = (k < 3) ? 8'he0 : ((k % 2) ? 8'h80 : 8'h60);
            if (k >= 1 && mv[7:5] > 3'h3) ea[5]++;
            @(posedge clk);
            m.multipath_metric <= mv;
            m.packet_done <= 1'b1;
            @(posedge clk);
            m.packet_done <= 1'b0;
        end
        s = 0;
        for (int k = 0; k < 64; k++) begin
            s += (k % 2) ? -3 : 0;
            @(posedge clk);
            m.tx_sample_valid <= 1'b1;
            m.tx_sample <= (k % 2) ? 8'hfd : 8'h00;
        end
        @(posedge clk);
        m.tx_sample_valid <= 1'b0;
        $display("Test stimulus done");
        for (int v = 0; v < 2; v++) begin
            if (v == 1) wr(8'h62, 8'hda);
            for (int i = 0; i < 8; i++) begin
                rd(ix[i], v ? ea[i] : eb[i]);
            end
            rd(8'h64, 8'h3c);
            rd(8'h74, 8'(s >>> 6));
            rd(8'h7a, 8'h7f);
        end
        rd(8'h62, 8'hda);
        $display("Test views done");
        wr(8'h60, 8'h35);
        @(posedge clk);
        chk({1'b0, seed}, 8'h35);
        wr(8'h0a, 8'h08);
        @(posedge clk);
        chk({1'b0, seed}, 8'h5a);
        rd(8'h0a, 8'h08);
        $display("Test seed done");
        wb(1'b0, 8'h76, 8'h00, 4'hf, d, e);
        chk({7'h0, e}, 8'h01);
        chk(d, 8'h00);
        wr(8'h64, 8'hff);
        rd(8'h64, 8'h3c);
        wb(1'b1, 8'h48, 8'he0, 4'he, d, e);
        rd(8'h48, 8'h60);
        $display("Test refusals done");
        print_verdict();
    end
endmodule // bbr_status_regs_test
